// ==== src/smm_controller.sv ====
`timescale 1ns/10ps
module smm_controller
  import smm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  smm_link_if.host lnk,
  input wire logic [3:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [31:0] cpu_rdata,
  output logic irq
);

  logic io_wr_reg;
  logic io_rd_reg;
  logic [7:0] io_addr_reg;
  logic [7:0] io_wdata_reg;
  logic io_pend_reg;
  logic io_pend_rd_reg;
  logic [7:0] io_result_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [SMM_ADDR_W-1:0] mem_addr_reg;
  logic mem_busy_reg;
  smm_hit_type hit_reg;
  logic par_prev_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [2:0] events;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic io_go;
  logic mem_go;

  // ----------------------------------------------------------------
  // link strobes
  // ----------------------------------------------------------------
  // one I/O and one memory access at a time, and the two can overlap; commands while busy are ignored
  assign io_go = cpu_wr && cpu_addr == SMM_H_IO_CMD && !io_pend_reg &&
                 !io_wr_reg && !io_rd_reg;
  assign mem_go = cpu_wr && cpu_addr == SMM_H_MEM_CMD && !mem_busy_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_wr_reg <= 1'b0;
      io_rd_reg <= 1'b0;
      io_addr_reg <= 8'h00;
      io_wdata_reg <= 8'h00;
      io_pend_reg <= 1'b0;
      io_pend_rd_reg <= 1'b0;
      io_result_reg <= 8'h00;
    end else begin
      io_wr_reg <= io_go && !cpu_wdata[SMM_IO_READ_BIT];
      io_rd_reg <= io_go && cpu_wdata[SMM_IO_READ_BIT];
      io_pend_reg <= io_wr_reg || io_rd_reg;
      io_pend_rd_reg <= io_rd_reg;
      if (io_go) begin
        io_addr_reg <= cpu_wdata[SMM_IO_ADDR_LSB +: 8];
        io_wdata_reg <= cpu_wdata[SMM_IO_DATA_LSB +: 8]; // see R2, R13
      end
      if (io_pend_reg && io_pend_rd_reg) begin
        io_result_reg <= lnk.io_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_busy_reg <= 1'b0;
      hit_reg <= SMM_HIT_NONE;
    end else begin
      mem_req_reg <= mem_go;
      if (mem_go) begin
        mem_we_reg <= cpu_wdata[SMM_MEM_WE_BIT];
        mem_busy_reg <= 1'b1;
      end else if (lnk.mem_ack) begin
        mem_busy_reg <= 1'b0;
        hit_reg <= lnk.mem_hit;
      end
      if (cpu_wr && cpu_addr == SMM_H_MEM_ADDR && !mem_busy_reg) begin
        mem_addr_reg <= cpu_wdata[SMM_ADDR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status, mask and interrupt
  // ----------------------------------------------------------------
  assign events[SMM_EV_IO] = io_pend_reg;
  assign events[SMM_EV_MEM] = lnk.mem_ack && mem_busy_reg;
  assign events[SMM_EV_PAR] = lnk.parity_err && !par_prev_reg; // see R12

  // set beats the read-clear so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
      par_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      par_prev_reg <= lnk.parity_err;
      if (cpu_rd && cpu_addr == SMM_H_STATUS) begin
        status_reg <= events;
        irq_reg <= |(events & mask_reg);
      end else begin
        status_reg <= status_reg | events;
        irq_reg <= |((status_reg | events) & mask_reg);
      end
      if (cpu_wr && cpu_addr == SMM_H_MASK) begin
        mask_reg <= cpu_wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= 32'h00000000;
      if (cpu_rd) begin
        unique case (cpu_addr)
          SMM_H_MEM_ADDR: rdata_reg <= 32'(mem_addr_reg);
          SMM_H_STATUS: rdata_reg <= 32'(status_reg);
          SMM_H_MASK: rdata_reg <= 32'(mask_reg);
          SMM_H_RESULT: begin
            rdata_reg[7:0] <= io_result_reg;
            rdata_reg[SMM_RES_HIT_LSB +: 2] <= hit_reg;
            rdata_reg[SMM_RES_BUSY_BIT] <= mem_busy_reg || io_pend_reg ||
                                           io_wr_reg || io_rd_reg;
            rdata_reg[SMM_RES_PAR_BIT] <= lnk.parity_err;
          end
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign lnk.io_wr = io_wr_reg;
  assign lnk.io_rd = io_rd_reg;
  assign lnk.io_addr = io_addr_reg;
  assign lnk.io_wdata = io_wdata_reg;
  assign lnk.mem_req = mem_req_reg;
  assign lnk.mem_we = mem_we_reg;
  assign lnk.mem_addr = mem_addr_reg;
  assign cpu_rdata = rdata_reg;
  assign irq = irq_reg;

endmodule // smm_controller

// ==== src/smm_decoder.sv ====
`timescale 1ns/10ps
module smm_decoder
  import smm_pkg::*;
#(
  parameter int ROM_CYCLES = SMM_ROM_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  smm_link_if.dev lnk,
  input wire logic parity_fault,
  output logic ram_sel,
  output logic ram_we,
  output logic [SMM_PHYS_W-1:0] ram_phys_addr,
  output logic rom_sel,
  output logic [15:0] rom_word_addr,
  output logic parity_check_en,
  output logic [3:0] blk_enable
);

  // four-bit wait counter, and at least one waiting clock
  if (ROM_CYCLES < 2 || ROM_CYCLES > 15) begin : g_bad_rom_cycles
    $error("ROM_CYCLES must lie in 2..15");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lower and upper megabyte enables of one card
  function automatic logic [1:0] smm_card_en(input logic [1:0] code);
    smm_card_en[0] = (code != SMM_SIZE_FIRST_OFF) && (code != SMM_SIZE_NONE);
    smm_card_en[1] = (code != SMM_SIZE_SECOND_OFF) &&
                     (code != SMM_SIZE_NONE);
  endfunction

  // k-th enabled block: {found, physical megabyte}
  function automatic logic [3:0] smm_pick(input logic [3:0] en,
                                          input logic [3:0] k);
    logic [3:0] r;
    logic [3:0] n;
    r = 4'h0;
    n = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        if (n == k) begin
          r = {1'b1, 3'(i + 1)};
        end
        n = n + 4'h1;
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // map registers
  // ----------------------------------------------------------------
  logic [7:0] conn1_reg;
  logic [7:0] conn2_reg;
  logic [7:0] conn1_next;
  logic [7:0] io_rdata_reg;

  always_comb begin
    conn1_next = conn1_reg;
    if (lnk.io_wr && lnk.io_addr == SMM_REG_CONN1_ADDR) begin
      conn1_next = lnk.io_wdata; // see R1
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conn1_reg <= SMM_REG_CONN1_RESET;
      conn2_reg <= SMM_REG_CONN2_RESET;
    end else begin
      conn1_reg <= conn1_next;
      if (lnk.io_wr && lnk.io_addr == SMM_REG_CONN2_ADDR) begin
        conn2_reg <= lnk.io_wdata; // see R1
      end
    end
  end

  // all eight bits stored, reserved ones included, so read-back is exact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata_reg <= 8'h00;
    end else if (lnk.io_rd) begin
      unique case (lnk.io_addr)
        SMM_REG_CONN1_ADDR: io_rdata_reg <= conn1_reg; // see R1
        SMM_REG_CONN2_ADDR: io_rdata_reg <= conn2_reg; // see R1
        default: io_rdata_reg <= 8'h00;
      endcase
    end else begin
      io_rdata_reg <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  logic rom_window_enable;
  logic split_block_disable;
  logic low512;
  logic [1:0] conn1_code;
  logic [1:0] conn2_code;
  logic [3:0] split_start;
  logic [3:0] blk_en;
  logic [23:0] low_top;
  logic [23:0] split_size;
  logic [23:0] split_base;

  assign rom_window_enable = conn1_reg[SMM_ROM_EN_BIT];
  assign split_block_disable = conn1_reg[SMM_SPLIT_DIS_BIT];
  assign low512 = conn1_reg[SMM_LOW512_BIT];
  assign conn1_code = conn1_reg[SMM_SIZE_LSB +: 2];
  assign conn2_code = conn2_reg[SMM_SIZE_LSB +: 2];
  assign split_start = conn2_reg[SMM_START_LSB +: 4];
  // code 11 on connector one is never written; it decodes as absent
  assign blk_en = {smm_card_en(conn2_code), smm_card_en(conn1_code)};
  // see R3, R4
  assign low_top = low512 ? SMM_LOW512_TOP : SMM_LOW640_TOP; // see R7, R8
  assign split_size = low512 ? SMM_SPLIT512_SIZE : SMM_SPLIT640_SIZE;
  assign split_base = {split_start, 20'h00000}; // see R14

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  smm_hit_type hit_next;
  logic [SMM_PHYS_W-1:0] phys_next;
  logic [3:0] pick;
  logic [23:0] a;
  logic [23:0] split_off;

  assign a = lnk.mem_addr;
  assign pick = smm_pick(blk_en, a[23:20] - 4'h1); // see R17
  assign split_off = a - split_base;

  always_comb begin
    hit_next = SMM_HIT_NONE;
    phys_next = '0;
    if (a < low_top) begin
      hit_next = SMM_HIT_RAM; // see R7, R8
      phys_next = a[SMM_PHYS_W-1:0];
    end else if (a >= SMM_ROM_BASE && a < SMM_ONE_MB) begin
      // window always backed by the top 128KB of the first megabyte
      phys_next = a[SMM_PHYS_W-1:0]; // see R5
      if (rom_window_enable) begin
        hit_next = lnk.mem_we ? SMM_HIT_RAM : SMM_HIT_ROM; // see R9
      end else begin
        hit_next = lnk.mem_we ? SMM_HIT_DROP : SMM_HIT_RAM; // see R10
      end
    end else if (a < SMM_ONE_MB) begin
      hit_next = SMM_HIT_NONE; // see R19
    end else if (!split_block_disable && a >= split_base &&
                 split_off < split_size) begin
      // split block sits in the first megabyte just above low RAM
      hit_next = SMM_HIT_RAM; // see R6, R18
      phys_next = SMM_PHYS_W'(low_top + split_off);
    end else if (pick[3]) begin
      hit_next = SMM_HIT_RAM; // see R17
      phys_next = {pick[2:0], a[19:0]};
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  typedef enum logic {
    SMM_IDLE,
    SMM_ROM_BUSY
  } smm_dev_state_type;

  smm_dev_state_type state_reg;
  logic [3:0] rom_cnt_reg;
  logic ack_reg;
  smm_hit_type hit_reg;
  logic ram_sel_reg;
  logic ram_we_reg;
  logic [SMM_PHYS_W-1:0] phys_reg;
  logic rom_sel_reg;
  logic [15:0] rom_addr_reg;

  // ROM is slow and narrow; it holds the cycle for ROM_CYCLES clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SMM_IDLE;
      rom_cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      hit_reg <= SMM_HIT_NONE;
      ram_sel_reg <= 1'b0;
      ram_we_reg <= 1'b0;
      phys_reg <= '0;
      rom_sel_reg <= 1'b0;
      rom_addr_reg <= 16'h0000;
    end else begin
      ack_reg <= 1'b0;
      ram_sel_reg <= 1'b0;
      unique case (state_reg)
        SMM_IDLE: begin
          if (lnk.mem_req) begin
            hit_reg <= hit_next;
            phys_reg <= phys_next;
            ram_we_reg <= lnk.mem_we;
            if (hit_next == SMM_HIT_ROM) begin
              state_reg <= SMM_ROM_BUSY; // see R11
              rom_sel_reg <= 1'b1;
              rom_addr_reg <= a[16:1]; // see R11
              rom_cnt_reg <= 4'(ROM_CYCLES - 1);
            end else begin
              ack_reg <= 1'b1;
              ram_sel_reg <= (hit_next == SMM_HIT_RAM);
            end
          end
        end
        SMM_ROM_BUSY: begin
          rom_cnt_reg <= rom_cnt_reg - 4'h1;
          if (rom_cnt_reg == 4'h1) begin
            state_reg <= SMM_IDLE;
            rom_sel_reg <= 1'b0;
            ack_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // parity latch
  // ----------------------------------------------------------------
  logic parity_err_reg;
  logic check_en_reg;
  logic [3:0] blk_en_reg;

  // a fault never latches during the clear; check_en_reg is low while the disable bit is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_err_reg <= 1'b0;
    end else if (parity_fault && check_en_reg) begin
      parity_err_reg <= 1'b1; // see R12
    end else if (conn1_reg[SMM_PAR_DIS_BIT]) begin
      parity_err_reg <= 1'b0; // see R12
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      check_en_reg <= 1'b0;
      blk_en_reg <= 4'h0;
    end else begin
      check_en_reg <= !conn1_next[SMM_PAR_DIS_BIT]; // see R12
      blk_en_reg <= blk_en;
    end
  end

  assign lnk.io_rdata = io_rdata_reg;
  assign lnk.mem_ack = ack_reg;
  assign lnk.mem_hit = hit_reg;
  assign lnk.parity_err = parity_err_reg;
  assign ram_sel = ram_sel_reg;
  assign ram_we = ram_we_reg;
  assign ram_phys_addr = phys_reg;
  assign rom_sel = rom_sel_reg;
  assign rom_word_addr = rom_addr_reg;
  assign parity_check_en = check_en_reg;
  assign blk_enable = blk_en_reg;

endmodule // smm_decoder

// ==== src/smm_link_if.sv ====
`timescale 1ns/10ps
interface smm_link_if;
  import smm_pkg::*;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic mem_req;
  logic mem_we;
  logic [SMM_ADDR_W-1:0] mem_addr;
  logic mem_ack;
  smm_hit_type mem_hit;
  logic parity_err;

  modport dev (
    input io_wr, io_rd, io_addr, io_wdata, mem_req, mem_we, mem_addr,
    output io_rdata, mem_ack, mem_hit, parity_err
  );
  modport host (
    output io_wr, io_rd, io_addr, io_wdata, mem_req, mem_we, mem_addr,
    input io_rdata, mem_ack, mem_hit, parity_err
  );
endinterface // smm_link_if

// ==== src/smm_pkg.sv ====
// How it works
// R1 - both map registers read back what was written
// R2 - software writes ones into bits seven and six
// R3 - connector one size codes; eleven never written
// R4 - connector two code eleven disables whole card
// R5 - top 128KB of first megabyte shadows ROM
// R6 - split block relocated when enabled, else off
// R7 - low split clear: 640KB low, 256KB split
// R8 - low split set: 512KB low, 384KB split
// R9 - ROM enabled: window reads ROM, writes RAM
// R10 - ROM disabled: window reads RAM, writes dropped
// R11 - ROM accesses are 16-bit, longer cycle
// R12 - parity checked while disable bit is zero
// R13 - split start zero only with split disabled
// R14 - split start is megabyte number 1 to 15
// R15 - split disabled once memory reaches 16MB
// R16 - split start is one plus X plus Y
// R17 - board memory enabled in aligned 1MB blocks
// R18 - split hit between start and start plus size
// R19 - video and channel ROM ranges never claimed
package smm_pkg;

  // ----------------------------------------------------------------
  // map registers on the link
  // ----------------------------------------------------------------
  localparam logic [7:0] SMM_REG_CONN2_ADDR = 8'he0;
  localparam logic [7:0] SMM_REG_CONN1_ADDR = 8'he1;
  localparam logic [7:0] SMM_REG_CONN2_RESET = 8'hf0;
  localparam logic [7:0] SMM_REG_CONN1_RESET = 8'hcb;
  localparam int SMM_PAR_DIS_BIT = 0;
  localparam int SMM_ROM_EN_BIT = 1;
  localparam int SMM_LOW512_BIT = 2;
  localparam int SMM_SPLIT_DIS_BIT = 3;
  localparam int SMM_SIZE_LSB = 4;
  localparam int SMM_START_LSB = 0;
  localparam logic [1:0] SMM_SIZE_FIRST_OFF = 2'h1;
  localparam logic [1:0] SMM_SIZE_SECOND_OFF = 2'h2;
  localparam logic [1:0] SMM_SIZE_NONE = 2'h3;

  // ----------------------------------------------------------------
  // address map (24-bit processor address)
  // ----------------------------------------------------------------
  localparam int SMM_ADDR_W = 24;
  localparam int SMM_PHYS_W = 23;
  localparam logic [23:0] SMM_LOW640_TOP = 24'h0a0000;
  localparam logic [23:0] SMM_LOW512_TOP = 24'h080000;
  localparam logic [23:0] SMM_ROM_BASE = 24'h0e0000;
  localparam logic [23:0] SMM_ONE_MB = 24'h100000;
  localparam logic [23:0] SMM_SPLIT640_SIZE = 24'h040000;
  localparam logic [23:0] SMM_SPLIT512_SIZE = 24'h060000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SMM_CLK_NS = 40;
  localparam int SMM_ROM_CYCLE_NS = 200;
  localparam int SMM_ROM_CYCLES = (SMM_ROM_CYCLE_NS + SMM_CLK_NS - 1)
                                  / SMM_CLK_NS;

  typedef enum logic [1:0] {
    SMM_HIT_NONE,
    SMM_HIT_RAM,
    SMM_HIT_ROM,
    SMM_HIT_DROP
  } smm_hit_type;

  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] SMM_H_IO_CMD = 4'h0;
  localparam logic [3:0] SMM_H_MEM_ADDR = 4'h1;
  localparam logic [3:0] SMM_H_MEM_CMD = 4'h2;
  localparam logic [3:0] SMM_H_STATUS = 4'h3;
  localparam logic [3:0] SMM_H_RESULT = 4'h4;
  localparam logic [3:0] SMM_H_MASK = 4'h5;
  localparam int SMM_IO_DATA_LSB = 0;
  localparam int SMM_IO_ADDR_LSB = 8;
  localparam int SMM_IO_READ_BIT = 16;
  localparam int SMM_MEM_WE_BIT = 0;
  localparam int SMM_EV_IO = 0;
  localparam int SMM_EV_MEM = 1;
  localparam int SMM_EV_PAR = 2;
  localparam int SMM_RES_HIT_LSB = 8;
  localparam int SMM_RES_BUSY_BIT = 12;
  localparam int SMM_RES_PAR_BIT = 13;

endpackage

// ==== testbench/smm_link_sva.sv ====
`timescale 1ns/10ps
module smm_link_sva
  import smm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [SMM_ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire smm_hit_type mem_hit,
  input wire logic parity_err
);
  logic [7:0] e1_q;
  logic [7:0] e0_q;
  logic win;
  logic low_hit;
  logic rom_on;
  logic io_known;

  // ----------------------------------------------------------------
  // shadow of the map registers, so decode is judged from the wire
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e1_q <= SMM_REG_CONN1_RESET;
    end else if (io_wr && io_addr == SMM_REG_CONN1_ADDR) begin
      e1_q <= io_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e0_q <= SMM_REG_CONN2_RESET;
    end else if (io_wr && io_addr == SMM_REG_CONN2_ADDR) begin
      e0_q <= io_wdata;
    end
  end

  assign win = mem_addr >= SMM_ROM_BASE && mem_addr < SMM_ONE_MB;
  assign rom_on = e1_q[SMM_ROM_EN_BIT];
  assign low_hit = mem_addr < (e1_q[SMM_LOW512_BIT] ? SMM_LOW512_TOP
                                                    : SMM_LOW640_TOP);
  assign io_known = io_addr == SMM_REG_CONN1_ADDR
                    || io_addr == SMM_REG_CONN2_ADDR;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // default ROM_CYCLES: request edge plus four waiting cycles
  sequence rom_wait_s;
    !mem_ack [*4] ##1 (mem_ack && mem_hit == SMM_HIT_ROM);
  endsequence

  sequence ram_ack_s;
    mem_ack && mem_hit == SMM_HIT_RAM;
  endsequence

  chk_rd_conn1: assert property (
    io_rd && io_addr == SMM_REG_CONN1_ADDR |=> io_rdata == $past(e1_q))
    else $error("conn1 register read back wrong");
  chk_rd_conn2: assert property (
    io_rd && io_addr == SMM_REG_CONN2_ADDR |=> io_rdata == $past(e0_q))
    else $error("conn2 register read back wrong");
  chk_rd_unmapped: assert property (
    !(io_rd && io_known) |=> io_rdata == 8'h00)
    else $error("read data outside a mapped read");
  chk_low_ram: assert property (mem_req && low_hit |=> ram_ack_s)
    else $error("low memory not sent to RAM");
  chk_rom_read: assert property (
    mem_req && !mem_we && win && rom_on |=> rom_wait_s)
    else $error("ROM read hit or length wrong");
  chk_win_wram: assert property (
    mem_req && win && (mem_we == rom_on) |=> ram_ack_s)
    else $error("window access not sent to RAM");
  chk_win_drop: assert property (
    mem_req && mem_we && win && !rom_on
    |=> mem_ack && mem_hit == SMM_HIT_DROP)
    else $error("protected window write not dropped");
  chk_gap_none: assert property (
    mem_req && !low_hit && mem_addr < SMM_ROM_BASE
    |=> mem_ack && mem_hit == SMM_HIT_NONE)
    else $error("unassigned low range claimed");
  chk_ack_pulse: assert property (mem_ack |=> !mem_ack)
    else $error("ack longer than one cycle");
  chk_par_clear: assert property (
    io_wr && io_addr == SMM_REG_CONN1_ADDR && io_wdata[SMM_PAR_DIS_BIT]
    |-> ##[1:3] !parity_err)
    else $error("parity error not cleared");
endmodule // smm_link_sva

// ==== testbench/system_memory_map_decoder_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module system_memory_map_decoder_tb_top
  import smm_pkg::*;
;
  logic clk, rst, parity_fault, cpu_wr, cpu_rd, irq;
  logic [3:0] cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata;
  logic ram_sel, ram_we, rom_sel, pce, cur_we;
  logic [22:0] phys;
  logic [15:0] rom_wa;
  logic [3:0] blk;
  int cur_a;
  int n_errors = 0, comparisons = 0, seed = 28237, cycles = 0;
  logic [7:0] m_e0, m_e1, q;
  int addr_q[$];

  smm_link_if link ();
  smm_decoder smm_decoder_i (.clk(clk), .rst(rst), .lnk(link),
    .parity_fault(parity_fault), .ram_sel(ram_sel), .ram_we(ram_we),
    .ram_phys_addr(phys), .rom_sel(rom_sel), .rom_word_addr(rom_wa),
    .parity_check_en(pce), .blk_enable(blk));
  smm_controller smm_controller_i (.clk(clk), .rst(rst), .lnk(link),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .irq(irq));
  smm_link_sva smm_link_sva_i (.clk(clk), .rst(rst),
    .io_wr(link.io_wr), .io_rd(link.io_rd), .io_addr(link.io_addr),
    .io_wdata(link.io_wdata), .io_rdata(link.io_rdata),
    .mem_req(link.mem_req), .mem_we(link.mem_we),
    .mem_addr(link.mem_addr), .mem_ack(link.mem_ack),
    .mem_hit(link.mem_hit), .parity_err(link.parity_err));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a full run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // cpu port, controller and link helpers
  // ----------------------------------------------------------------
  task automatic cpu_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  task automatic cpu_r(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    @(posedge clk);
    d = cpu_rdata;
  endtask

  // status read clears every bit not set again by an event in that cycle, so each caller waits its own event
  task automatic wait_ev(input int b);
    logic [31:0] s;
    s = '0;
    for (int k = 0; k < 40 && s[b] !== 1'b1; k++)
      cpu_r(SMM_H_STATUS, s);
    `CHK(s[b], 1'b1)
  endtask

  task automatic io_t(input logic [7:0] a, input logic [7:0] d,
                      input logic rd, output logic [7:0] r8);
    logic [31:0] r;
    cpu_w(SMM_H_IO_CMD, {15'h0, rd, a, d});
    wait_ev(SMM_EV_IO);
    cpu_r(SMM_H_RESULT, r);
    r8 = r[7:0];
  endtask

  task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r8;
    io_t(a, d, 1'b0, r8);
    if (a == SMM_REG_CONN2_ADDR) m_e0 = d;
    if (a == SMM_REG_CONN1_ADDR) m_e1 = d;
  endtask

  function automatic logic [1:0] model_hit(input int a, input bit we);
    int top, st, sz, cnt;
    bit [3:0] en;
    top = m_e1[2] ? 'h80000 : 'ha0000;
    st = m_e0[3:0] * 'h100000;
    sz = m_e1[2] ? 'h60000 : 'h40000;
    en = {~m_e0[5], ~m_e0[4], ~m_e1[5], ~m_e1[4]};
    cnt = en[0] + en[1] + en[2] + en[3];
    if (a < top) return SMM_HIT_RAM;
    if (a >= 'he0000 && a < 'h100000) begin
      if (m_e1[1]) return we ? SMM_HIT_RAM : SMM_HIT_ROM;
      return we ? SMM_HIT_DROP : SMM_HIT_RAM;
    end
    if (a < 'h100000) return SMM_HIT_NONE;
    if (!m_e1[3] && a >= st && a < st + sz)
      return SMM_HIT_RAM;
    if (a / 'h100000 - 1 < cnt) return SMM_HIT_RAM;
    return SMM_HIT_NONE;
  endfunction

  task automatic mem_t(input int a, input logic we);
    logic [31:0] r;
    cur_a = a;
    cur_we = we;
    cpu_w(SMM_H_MEM_ADDR, {8'h0, a[23:0]});
    cpu_w(SMM_H_MEM_CMD, {31'h0, we});
    wait_ev(SMM_EV_MEM);
    cpu_r(SMM_H_RESULT, r);
    `CHK(r[9:8], model_hit(a, we))
  endtask

  // board megabytes lie below the split start, so a RAM hit there is split
  function automatic int model_phys(input int a);
    int n, st;
    bit [3:0] en;
    en = ~{m_e0[5:4], m_e1[5:4]};
    n = a / 'h100000;
    st = m_e0[3:0] * 'h100000;
    if (n == 0) return a;
    if (!m_e1[3] && a >= st)
      return (m_e1[2] ? 'h80000 : 'ha0000) + a - st;
    for (int i = 0; i < 4; i++) begin
      n -= en[i];
      if (en[i] && n == 0)
        return (i + 1) * 'h100000 + a % 'h100000;
    end
    return 0;
  endfunction

  // memory side of each cycle, looked at while its select stands
  always @(posedge clk) begin
    if (ram_sel) begin
      `CHK(phys, model_phys(cur_a))
      `CHK(ram_we, cur_we)
    end
    if (rom_sel) `CHK(rom_wa, cur_a[16:1])
  end

  task automatic fault();
    @(posedge clk);
    parity_fault <= 1'b1;
    @(posedge clk);
    parity_fault <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int st, x;
    rst = 1'b1;
    parity_fault = 1'b0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = 4'h0;
    cpu_wdata = 32'h0;
    m_e0 = SMM_REG_CONN2_RESET;
    m_e1 = SMM_REG_CONN1_RESET;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    io_t(SMM_REG_CONN1_ADDR, 8'h00, 1'b1, q);
    `CHK(q, m_e1)
    io_t(SMM_REG_CONN2_ADDR, 8'h00, 1'b1, q);
    `CHK(q, m_e0)
    reg_w(8'h55, 8'h12);
    io_t(8'h55, 8'h00, 1'b1, q);
    `CHK(q, 8'h00)
    fault();
    cpu_r(SMM_H_RESULT, r);
    `CHK(r[13], 1'b0)
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      // start sits above the board and channel megabytes
      x = (i % 3 == 0 ? 2 : 1) + (i % 4 == 0 ? 2 : i % 4 == 3 ? 0 : 1);
      st = 1 + x + {$random(seed)} % (15 - x);
      // upper two bits always ones, conn1 never 11, start never 0
      reg_w(SMM_REG_CONN1_ADDR, {2'b11, 2'(i % 3), 3'(i), 1'b1});
      reg_w(SMM_REG_CONN2_ADDR, {2'b11, 2'(i % 4), 4'(st)});
      io_t(SMM_REG_CONN2_ADDR, 8'h00, 1'b1, q);
      `CHK(q, m_e0)
      `CHK(blk[3:2], ~m_e0[5:4])
      `CHK(blk[1:0], ~m_e1[5:4])
      addr_q = '{0, 'h7ffff, 'h80000, 'h9ffff, 'ha0000, 'hc0000,
                 'hdffff, 'he0000, 'hfffff, st * 'h100000 - 1,
                 st * 'h100000, st * 'h100000 + 'h3ffff,
                 st * 'h100000 + 'h40000, st * 'h100000 + 'h5ffff,
                 st * 'h100000 + 'h60000, 'h100000, 'h250000, 'h480000,
                 {$random(seed)} % 'h1000000};
      foreach (addr_q[k]) mem_t(addr_q[k], 1'($random(seed)));
      mem_t('he8000, 1'b0);
      mem_t('he8000, 1'b1);
    end
    $display("test address map done");
    cpu_w(SMM_H_MASK, 32'h0);
    reg_w(SMM_REG_CONN1_ADDR, 8'hca);
    `CHK(pce, 1'b1)
    fault();
    `CHK(irq, 1'b0)
    cpu_r(SMM_H_RESULT, r);
    `CHK(r[13], 1'b1)
    cpu_w(SMM_H_MASK, 32'h4);
    fault();
    `CHK(irq, 1'b1)
    cpu_r(SMM_H_STATUS, r);
    `CHK(r[SMM_EV_PAR], 1'b1)
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    reg_w(SMM_REG_CONN1_ADDR, 8'hcb);
    reg_w(SMM_REG_CONN1_ADDR, 8'hca);
    cpu_r(SMM_H_RESULT, r);
    `CHK(r[13], 1'b0)
    $display("test parity done");
    summarize();
  end
endmodule // system_memory_map_decoder_tb_top
